/* File: core/dcfpf_pkg.sv */
// Purpose: shared constants and types for the programmable-flag buffer
// Assumes: one clock, synchronous active-high system reset
// Notes: offsets are 16-bit values built from two 8-bit registers
package dcfpf_pkg;
    localparam int DATA_W = 9;
    localparam int DEPTH_DEF = 64;
    localparam int OFFS_W = 8;
    localparam int OFFS_NUM = 4;
    localparam int OFFS_SEL_W = 2;
    localparam int CMP_W = 17;
    // offset register positions in the load sequence
    localparam logic [1:0] OFFS_AE_LOW = 2'h0;
    localparam logic [1:0] OFFS_AE_HIGH = 2'h1;
    localparam logic [1:0] OFFS_AF_LOW = 2'h2;
    localparam logic [1:0] OFFS_AF_HIGH = 2'h3;
    localparam logic [7:0] OFFS_LOW_RST = 8'h07;
    localparam logic [7:0] OFFS_HIGH_RST = 8'h00;
    localparam logic [8:0] DATA_RST = 9'h000;

    typedef enum logic {
        DCFPF_MODE_TWO_EN,
        DCFPF_MODE_LOAD
    } dcfpf_mode_e;

    typedef struct packed {
        logic empty_n;
        logic full_n;
        logic almost_empty_n;
        logic almost_full_n;
    } dcfpf_flags_s;

    localparam dcfpf_flags_s FLAGS_RST = '{empty_n: 1'b0, full_n: 1'b1,
                                           almost_empty_n: 1'b0, almost_full_n: 1'b1};
endpackage : dcfpf_pkg

/* File: core/dcfpf_top.sv */
// Purpose: buffer with empty, full and programmable almost flags
// Assumes: write and read sides share clk_sys_in; pins are synchronous
// Notes: storage is a separate parameterised module in this file
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module dcfpf_store #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16,
    parameter int CNT_W = $clog2(DEPTH + 1)
) (
    input wire logic clk_sys_in,
    input wire logic clear_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out,
    output logic [CNT_W-1:0] count_out
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PTR_W-1:0] wr_ptr_ff;
    logic [PTR_W-1:0] rd_ptr_ff;
    logic [CNT_W-1:0] count_ff;
    logic push;
    logic pop;

    assign in_ready_out = (count_ff != CNT_W'(DEPTH));
    assign out_valid_out = (count_ff != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_ready_in && out_valid_out;
    assign out_data_out = mem_ff[rd_ptr_ff];
    assign count_out = count_ff;

    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (clear_in) begin
            wr_ptr_ff <= '0;
        end else if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == PTR_LAST) ? '0 : wr_ptr_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (clear_in) begin
            rd_ptr_ff <= '0;
        end else if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == PTR_LAST) ? '0 : rd_ptr_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (clear_in) begin
            count_ff <= '0;
        end else if (push && !pop) begin
            count_ff <= count_ff + 1'b1;
        end else if (pop && !push) begin
            count_ff <= count_ff - 1'b1;
        end
    end
endmodule : dcfpf_store

////////////////////////////////////////////////////////////////////////////////
module dcfpf_top #(
    parameter int DEPTH = dcfpf_pkg::DEPTH_DEF
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic reset_n_in,
    input wire logic write_enable_primary_n_in,
    input wire logic write_enable_second_or_offset_load_in,
    input wire logic read_enable_primary_n_in,
    input wire logic read_enable_secondary_n_in,
    input wire logic output_enable_n_in,
    input wire logic [dcfpf_pkg::DATA_W-1:0] write_data_in,
    output logic [dcfpf_pkg::DATA_W-1:0] read_data_out,
    output logic read_data_oe_out,
    output logic empty_flag_n_out,
    output logic full_flag_n_out,
    output logic almost_empty_flag_n_out,
    output logic almost_full_flag_n_out
);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam int CW = dcfpf_pkg::CMP_W;

    logic rst;
    dcfpf_pkg::dcfpf_mode_e mode_ff;
    dcfpf_pkg::dcfpf_mode_e nxt_mode;
    dcfpf_pkg::dcfpf_flags_s flags;
    dcfpf_pkg::dcfpf_flags_s nxt_flags;
    logic empty_n_ff;
    logic full_n_ff;
    logic almost_empty_n_ff;
    logic almost_full_n_ff;
    logic [dcfpf_pkg::DATA_W-1:0] nxt_read_data;
    logic [dcfpf_pkg::OFFS_W-1:0] offs_ff [dcfpf_pkg::OFFS_NUM];
    logic [dcfpf_pkg::OFFS_SEL_W-1:0] offs_wr_sel_ff;
    logic [dcfpf_pkg::OFFS_SEL_W-1:0] offs_rd_sel_ff;
    logic [dcfpf_pkg::DATA_W-1:0] read_data_ff;
    logic wr_data_req;
    logic rd_both_low;
    logic load_active;
    logic offs_wr;
    logic offs_rd;
    logic in_ready;
    logic out_valid;
    logic wr_take;
    logic rd_take;
    logic [dcfpf_pkg::DATA_W-1:0] store_data;
    logic [CNT_W-1:0] count;
    logic [CW-1:0] ae_n;
    logic [CW-1:0] af_m;

    assign rst = sys_rst_in || !reset_n_in;
    assign load_active = (mode_ff == dcfpf_pkg::DCFPF_MODE_LOAD)
                         && !write_enable_second_or_offset_load_in;
    assign rd_both_low = !read_enable_primary_n_in && !read_enable_secondary_n_in;

    // mode from second input
    // only the device reset pin samples the mode; system reset forces two-enable
    always_comb begin
        nxt_mode = mode_ff;
        if (sys_rst_in) begin
            nxt_mode = dcfpf_pkg::DCFPF_MODE_TWO_EN;
        end else if (!reset_n_in) begin
            nxt_mode = write_enable_second_or_offset_load_in
                       ? dcfpf_pkg::DCFPF_MODE_TWO_EN : dcfpf_pkg::DCFPF_MODE_LOAD;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        mode_ff <= nxt_mode;
    end

    always_comb begin
        case (mode_ff)
            dcfpf_pkg::DCFPF_MODE_TWO_EN: begin
                wr_data_req = !write_enable_primary_n_in
                              && write_enable_second_or_offset_load_in;
            end
            dcfpf_pkg::DCFPF_MODE_LOAD: begin
                wr_data_req = !write_enable_primary_n_in && !load_active;
            end
            default: begin
                wr_data_req = 1'b0;
            end
        endcase
    end

    assign wr_take = wr_data_req && in_ready && flags.full_n && !rst;
    assign rd_take = rd_both_low && !load_active && out_valid && flags.empty_n && !rst;

    assign offs_wr = load_active && !write_enable_primary_n_in && !rst;
    assign offs_rd = load_active && rd_both_low && !rst;

    dcfpf_store #(
        .WIDTH(dcfpf_pkg::DATA_W),
        .DEPTH(DEPTH),
        .CNT_W(CNT_W)
    ) u_store (
        .clk_sys_in(clk_sys_in),
        .clear_in(rst),
        .in_valid_in(wr_take),
        .in_ready_out(in_ready),
        .in_data_in(write_data_in),
        .out_valid_out(out_valid),
        .out_ready_in(rd_take),
        .out_data_out(store_data),
        .count_out(count)
    );

    ////////////////////////////////////////////////////////////////////////////
    // default offsets of seven
    generate
        for (genvar i = 0; i < dcfpf_pkg::OFFS_NUM; i++) begin : g_offs
            localparam logic [dcfpf_pkg::OFFS_SEL_W-1:0] SEL = dcfpf_pkg::OFFS_SEL_W'(i);
            localparam logic [dcfpf_pkg::OFFS_W-1:0] RST_VAL = ((i % 2) == 0)
                ? dcfpf_pkg::OFFS_LOW_RST : dcfpf_pkg::OFFS_HIGH_RST;
            always_ff @(posedge clk_sys_in) begin
                if (rst) begin
                    offs_ff[i] <= RST_VAL;
                end else if (offs_wr && offs_wr_sel_ff == SEL) begin
                    offs_ff[i] <= write_data_in[dcfpf_pkg::OFFS_W-1:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_in) begin
        if (rst) begin
            offs_wr_sel_ff <= dcfpf_pkg::OFFS_AE_LOW;
        end else if (offs_wr) begin
            offs_wr_sel_ff <= offs_wr_sel_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst) begin
            offs_rd_sel_ff <= dcfpf_pkg::OFFS_AE_LOW;
        end else if (offs_rd) begin
            offs_rd_sel_ff <= offs_rd_sel_ff + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output register
    // a refused read leaves the last good word in place
    always_comb begin
        nxt_read_data = read_data_ff;
        if (rst) begin
            nxt_read_data = dcfpf_pkg::DATA_RST;
        end else if (offs_rd) begin
            nxt_read_data = {1'b0, offs_ff[offs_rd_sel_ff]};
        end else if (rd_take) begin
            nxt_read_data = store_data;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        read_data_ff <= nxt_read_data;
    end

    assign read_data_out = read_data_ff;
    assign read_data_oe_out = !output_enable_n_in;

    ////////////////////////////////////////////////////////////////////////////
    // flags are one clock behind the count; gating on both keeps it safe
    assign ae_n = {1'b0, offs_ff[dcfpf_pkg::OFFS_AE_HIGH], offs_ff[dcfpf_pkg::OFFS_AE_LOW]};
    assign af_m = {1'b0, offs_ff[dcfpf_pkg::OFFS_AF_HIGH], offs_ff[dcfpf_pkg::OFFS_AF_LOW]};

    // next flag levels from the settled word count
    always_comb begin
        nxt_flags.empty_n = (count != '0);
        nxt_flags.full_n = (count != CNT_W'(DEPTH));
        nxt_flags.almost_empty_n = (CW'(count) > ae_n);
        nxt_flags.almost_full_n = ((CW'(count) + af_m) < CW'(DEPTH));
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst) begin
            empty_n_ff <= dcfpf_pkg::FLAGS_RST.empty_n;
        end else begin
            empty_n_ff <= nxt_flags.empty_n;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst) begin
            full_n_ff <= dcfpf_pkg::FLAGS_RST.full_n;
        end else begin
            full_n_ff <= nxt_flags.full_n;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst) begin
            almost_empty_n_ff <= dcfpf_pkg::FLAGS_RST.almost_empty_n;
        end else begin
            almost_empty_n_ff <= nxt_flags.almost_empty_n;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst) begin
            almost_full_n_ff <= dcfpf_pkg::FLAGS_RST.almost_full_n;
        end else begin
            almost_full_n_ff <= nxt_flags.almost_full_n;
        end
    end

    assign flags.empty_n = empty_n_ff;
    assign flags.full_n = full_n_ff;
    assign flags.almost_empty_n = almost_empty_n_ff;
    assign flags.almost_full_n = almost_full_n_ff;

    assign empty_flag_n_out = flags.empty_n;
    assign full_flag_n_out = flags.full_n;
    assign almost_empty_flag_n_out = flags.almost_empty_n;
    assign almost_full_flag_n_out = flags.almost_full_n;
endmodule : dcfpf_top

/* File: test/dcfpf_consumer.sv */
// Purpose: read-side consumer model that pulses both read enables
// Assumes: shared clock, one request per cycle
// Notes: enables start idle so the buffer sees no read at time zero
`timescale 1ns/1ps
module dcfpf_consumer (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic req_in,
    output logic read_enable_primary_n_n_out = 1'b1,
    output logic read_enable_secondary_n_n_out = 1'b1
);
    always_ff @(posedge clk_sys_in) begin
        read_enable_primary_n_n_out <= !(req_in && !rst_in);
        read_enable_secondary_n_n_out <= !(req_in && !rst_in);
    end
endmodule : dcfpf_consumer

/* File: test/dcfpf_properties.sv */
// Purpose: port-level checks for the flag buffer
// Assumes: single clock, both resets block checks except a_rst, which only the device reset blocks
// Notes: bound to every instance of the top
`timescale 1ns/1ps
module dcfpf_checker (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic reset_n_in,
    input wire logic write_enable_primary_n_in,
    input wire logic write_enable_second_or_offset_load_in,
    input wire logic read_enable_primary_n_in,
    input wire logic read_enable_secondary_n_in,
    input wire logic output_enable_n_in,
    input wire logic [8:0] read_data_out,
    input wire logic read_data_oe_out,
    input wire logic empty_flag_n_out,
    input wire logic full_flag_n_out,
    input wire logic almost_empty_flag_n_out,
    input wire logic almost_full_flag_n_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in || !reset_n_in);
    property p_oe; read_data_oe_out == !output_enable_n_in; endproperty
    a_oe: assert property (p_oe) else $error("drive enable wrong");
    property p_rst;
        disable iff (!reset_n_in) sys_rst_in |=> !empty_flag_n_out && full_flag_n_out
            && !almost_empty_flag_n_out && almost_full_flag_n_out && read_data_out == 9'h000;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_hold;
        $changed(read_data_out) |-> $past(!read_enable_primary_n_in
            && !read_enable_secondary_n_in) || $past(!reset_n_in) || $past(sys_rst_in);
    endproperty
    a_hold: assert property (p_hold) else $error("output moved without read");
    property p_ef_hold; $changed(empty_flag_n_out) |=> $stable(empty_flag_n_out); endproperty
    a_ef_hold: assert property (p_ef_hold) else $error("empty flag glitch");
    property p_ff_hold; $changed(full_flag_n_out) |=> $stable(full_flag_n_out); endproperty
    a_ff_hold: assert property (p_ff_hold) else $error("full flag glitch");
    property p_ef_stay;
        !empty_flag_n_out && write_enable_primary_n_in
            && $past(write_enable_primary_n_in) |=> !empty_flag_n_out;
    endproperty
    a_ef_stay: assert property (p_ef_stay) else $error("empty left without write");
    property p_ff_stay;
        !full_flag_n_out && read_enable_primary_n_in
            && $past(read_enable_primary_n_in) |=> !full_flag_n_out;
    endproperty
    a_ff_stay: assert property (p_ff_stay) else $error("full left without read");
    property p_wr;
        !empty_flag_n_out && full_flag_n_out && !write_enable_primary_n_in
            && write_enable_second_or_offset_load_in |-> ##2 empty_flag_n_out;
    endproperty
    a_wr: assert property (p_wr) else $error("write did not clear empty");
    property p_ae; almost_empty_flag_n_out |-> empty_flag_n_out; endproperty
    a_ae: assert property (p_ae) else $error("almost empty above empty");
endmodule : dcfpf_checker
bind dcfpf_top dcfpf_checker chk (.clk_sys_in, .sys_rst_in, .reset_n_in,
    .write_enable_primary_n_in, .write_enable_second_or_offset_load_in,
    .read_enable_primary_n_in, .read_enable_secondary_n_in, .output_enable_n_in,
    .read_data_out, .read_data_oe_out, .empty_flag_n_out, .full_flag_n_out,
    .almost_empty_flag_n_out, .almost_full_flag_n_out);

/* File: test/tb_dcfpf_top.sv */
// Purpose: self-checking bench for the flag buffer
// Assumes: 40 MHz clock, model counts words itself
// Notes: run needs about 710 cycles
`timescale 1ns/1ps
module tb_dcfpf_top;
    localparam int DEPTH = 64;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rst_n = 1'b1;
    logic wen_n = 1'b1;
    logic sec = 1'b1;
    logic oe_n = 1'b0;
    logic req = 1'b0;
    logic [8:0] din = 9'h000;
    logic [8:0] dout, last;
    logic read_enable_primary_n_n, read_enable_secondary_n_n, oe_out, ef_n, ff_n, ae_n, af_n;
    logic [8:0] q[$];
    int fails = 0;
    int n_compared = 0;
    int cnt = 0;
    always #12.5 clk = ~clk;
    dcfpf_top #(.DEPTH(DEPTH)) uut (.clk_sys_in(clk), .sys_rst_in(rst), .reset_n_in(rst_n),
        .write_enable_primary_n_in(wen_n), .write_enable_second_or_offset_load_in(sec),
        .read_enable_primary_n_in(read_enable_primary_n_n), .read_enable_secondary_n_in(read_enable_secondary_n_n),
        .output_enable_n_in(oe_n), .write_data_in(din), .read_data_out(dout),
        .read_data_oe_out(oe_out), .empty_flag_n_out(ef_n), .full_flag_n_out(ff_n),
        .almost_empty_flag_n_out(ae_n), .almost_full_flag_n_out(af_n));
    dcfpf_consumer cons (.clk_sys_in(clk), .rst_in(rst), .req_in(req),
        .read_enable_primary_n_n_out(read_enable_primary_n_n), .read_enable_secondary_n_n_out(read_enable_secondary_n_n));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    function automatic logic [8:0] exp_flags(input int n, input int m);
        return {5'h00, cnt != 0, cnt != DEPTH, cnt > n, cnt + m < DEPTH};
    endfunction : exp_flags
    task automatic tick(input int k);
        repeat (k) begin
            @(posedge clk);
            wen_n <= 1'b1;
            req <= 1'b0;
            oe_n <= 1'($urandom);
        end
    endtask : tick
    task automatic wr(input logic [8:0] d);
        @(posedge clk);
        wen_n <= 1'b0;
        din <= d;
        tick(3);
    endtask : wr
    task automatic rd();
        @(posedge clk);
        req <= 1'b1;
        tick(4);
    endtask : rd
    task automatic finish_test();
        if (fails == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [8:0] d;
        logic [8:0] offs[4];
        void'($urandom(32'ha3ce6d82));
        tick(12);
        rst <= 1'b0;
        tick(1);
        chk("reset flags", 9'({ef_n, ff_n, ae_n, af_n}), 9'(dcfpf_pkg::FLAGS_RST));
        chk("reset data", dout, dcfpf_pkg::DATA_RST);
        // load mode picked while device reset is low
        sec <= 1'b0;
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        tick(1);
        offs = '{9'h007, 9'h000, 9'h007, 9'h000};
        foreach (offs[i]) begin
            rd();
            chk("offset default", dout, offs[i]);
        end
        wr(9'h003);
        sec <= 1'b1;
        tick(2);
        sec <= 1'b0;
        wr(9'h000);
        wr(9'h005);
        wr(9'h000);
        offs = '{9'h003, 9'h000, 9'h005, 9'h000};
        foreach (offs[i]) begin
            rd();
            chk("offset readback", dout, offs[i]);
        end
        sec <= 1'b1;
        // overfill by two: the extra writes must be dropped
        repeat (DEPTH + 2) begin
            d = 9'($urandom);
            wr(d);
            if (cnt < DEPTH) begin
                q.push_back(d);
                cnt++;
            end
            chk("fill flags", 9'({ef_n, ff_n, ae_n, af_n}), exp_flags(3, 5));
        end
        last = 9'h000;
        repeat (DEPTH + 2) begin
            rd();
            if (cnt > 0) begin
                last = q.pop_front();
                cnt--;
            end
            chk("read data", dout, last);
            chk("drain flags", 9'({ef_n, ff_n, ae_n, af_n}), exp_flags(3, 5));
        end
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        sec <= 1'b0;
        wr(9'h1a5);
        chk("second enable low", 9'({ef_n, ff_n, ae_n, af_n}), exp_flags(7, 7));
        sec <= 1'b1;
        repeat (8) begin
            d = 9'($urandom);
            wr(d);
            q.push_back(d);
            cnt++;
            chk("two-enable flags", 9'({ef_n, ff_n, ae_n, af_n}), exp_flags(7, 7));
        end
        rd();
        chk("two-enable data", dout, q.pop_front());
        finish_test();
    end
    // nearly three times the expected run length
    initial begin
        repeat (2000) @(posedge clk);
        fails++;
        finish_test();
    end
endmodule : tb_dcfpf_top
